// ---- rtl/dpbs_host_ctrl.sv ----
`timescale 1ns/1ps
// Overview of operation
// - host drives subordinate inhibit high normally, low to block writes.
// - contention flags of stacked devices are ANDed into one.
// - exactly one device is primary, all others subordinate.
// - host holds address and enable stable before starting write strobe.
// - host deasserts select between repeated token reads.
// - host requests with zero and releases with one.
// - host claims ownership only after reading zero back.
// - host init writes one to every token.
module dpbs_host_ctrl (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // command port
  input wire logic cmd_valid_i,
  input wire dpbs_pkg::dpbs_cmd_t cmd_i,
  input wire logic [dpbs_pkg::ADDR_W-1:0] cmd_addr_i,
  input wire logic [dpbs_pkg::DATA_W-1:0] cmd_wdata_i,
  output logic cmd_ready_o,
  // response
  output logic rsp_valid_o,
  output logic rsp_granted_o,
  output logic rsp_blocked_o,
  output logic [dpbs_pkg::DATA_W-1:0] rsp_data_o,
  // array configuration
  input wire logic block_slave_writes_i,
  output logic slave_wr_inhibit_n_o,
  output logic [dpbs_pkg::NUM_DEV-1:0] role_sel_o,
  // device port pins
  output logic ce_n_o,
  output logic token_space_select_n_o,
  output logic oe_n_o,
  output logic rw_n_o,
  output logic [dpbs_pkg::ADDR_W-1:0] addr_o,
  output logic [dpbs_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic [dpbs_pkg::DATA_W-1:0] data_i,
  input wire logic [dpbs_pkg::NUM_DEV-1:0] busy_n_i
);
  typedef enum logic [5:0] {
    HC_IDLE = 6'h01,
    HC_ACCESS = 6'h02,
    HC_ACQ_WR = 6'h04,
    HC_ACQ_RD = 6'h08,
    HC_REL = 6'h10,
    HC_INIT = 6'h20
  } dpbs_hc_st_t;

  dpbs_cyc_if cyc ();

  dpbs_hc_st_t st_q;
  logic issued_q;
  logic [dpbs_pkg::TOK_IDX_W-1:0] idx_q;
  logic [dpbs_pkg::ADDR_W-1:0] addr_q;
  logic [dpbs_pkg::DATA_W-1:0] wdata_q;
  logic we_q;

  // token address: only the low index bits matter to the device
  function automatic logic [dpbs_pkg::ADDR_W-1:0] tok_addr(
    input logic [dpbs_pkg::TOK_IDX_W-1:0] idx);
    tok_addr = {{(dpbs_pkg::ADDR_W - dpbs_pkg::TOK_IDX_W){1'b0}}, idx};
  endfunction : tok_addr

  // ----------------------------------------------------------------
  // array configuration outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      role_sel_o <= dpbs_pkg::ROLE_SEL_RST;
    end else begin
      role_sel_o <= dpbs_pkg::ROLE_SEL_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      slave_wr_inhibit_n_o <= 1'b1;
    end else begin
      slave_wr_inhibit_n_o <= ~block_slave_writes_i;
    end
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q <= HC_IDLE;
      issued_q <= 1'b0;
      idx_q <= '0;
      addr_q <= dpbs_pkg::ADDR_RST;
      wdata_q <= dpbs_pkg::DATA_RST;
      we_q <= 1'b0;
      cmd_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_granted_o <= 1'b0;
      rsp_blocked_o <= 1'b0;
      rsp_data_o <= dpbs_pkg::DATA_RST;
    end else begin
      rsp_valid_o <= 1'b0;
      issued_q <= issued_q | (cyc.req & cyc.ready);
      unique case (st_q)
        HC_IDLE: begin
          cmd_ready_o <= 1'b1;
          issued_q <= 1'b0;
          if (cmd_valid_i && cmd_ready_o) begin
            cmd_ready_o <= 1'b0;
            addr_q <= cmd_addr_i;
            wdata_q <= cmd_wdata_i;
            idx_q <= cmd_addr_i[dpbs_pkg::TOK_IDX_W-1:0];
            we_q <= (cmd_i == dpbs_pkg::CMD_MEM_WR);
            unique case (cmd_i)
              dpbs_pkg::CMD_TOK_ACQ: st_q <= HC_ACQ_WR;
              dpbs_pkg::CMD_TOK_REL: st_q <= HC_REL;
              dpbs_pkg::CMD_TOK_INIT: begin
                idx_q <= '0;
                st_q <= HC_INIT;
              end
              default: st_q <= HC_ACCESS;
            endcase
          end
        end
        HC_ACCESS: begin
          if (cyc.done) begin
            rsp_valid_o <= 1'b1;
            rsp_granted_o <= 1'b0;
            rsp_blocked_o <= cyc.blocked;
            rsp_data_o <= cyc.rdata;
            st_q <= HC_IDLE;
          end
        end
        HC_ACQ_WR: begin
          if (cyc.done) begin
            issued_q <= 1'b0;
            st_q <= HC_ACQ_RD;
          end
        end
        HC_ACQ_RD: begin
          if (cyc.done) begin
            // a one read back means the other side holds it
            rsp_valid_o <= 1'b1;
            rsp_granted_o <= ~cyc.rdata[dpbs_pkg::TOK_BIT];
            rsp_blocked_o <= 1'b0;
            rsp_data_o <= cyc.rdata;
            st_q <= HC_IDLE;
          end
        end
        HC_REL: begin
          if (cyc.done) begin
            rsp_valid_o <= 1'b1;
            rsp_granted_o <= 1'b0;
            rsp_blocked_o <= 1'b0;
            rsp_data_o <= cyc.rdata;
            st_q <= HC_IDLE;
          end
        end
        HC_INIT: begin
          if (cyc.done) begin
            issued_q <= 1'b0;
            idx_q <= idx_q + 1'b1;
            if (idx_q == dpbs_pkg::TOK_IDX_W'(dpbs_pkg::TOKEN_CNT - 1)) begin
              rsp_valid_o <= 1'b1;
              rsp_granted_o <= 1'b0;
              rsp_blocked_o <= 1'b0;
              st_q <= HC_IDLE;
            end
          end
        end
        default: begin
          st_q <= HC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // request toward the pin engine
  // ----------------------------------------------------------------
  assign cyc.req = !issued_q && (st_q != HC_IDLE);
  assign cyc.tok = (st_q != HC_ACCESS);
  assign cyc.we = (st_q == HC_ACCESS) ? we_q : (st_q != HC_ACQ_RD);
  assign cyc.addr = (st_q == HC_ACCESS) ? addr_q : tok_addr(idx_q);
  // token writes: zero requests, one releases or frees at init
  always_comb begin
    unique case (st_q)
      HC_ACCESS: cyc.wdata = wdata_q;
      HC_ACQ_WR: cyc.wdata = dpbs_pkg::TOK_REQ;
      default: cyc.wdata = dpbs_pkg::TOK_FREE;
    endcase
  end

  dpbs_pin_cycle u_pin_cycle (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .cyc(cyc.eng),
    .ce_n_o(ce_n_o),
    .token_space_select_n_o(token_space_select_n_o),
    .oe_n_o(oe_n_o),
    .rw_n_o(rw_n_o),
    .addr_o(addr_o),
    .data_o(data_o),
    .data_oe_o(data_oe_o),
    .data_i(data_i),
    .busy_n_i(busy_n_i)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  AST_ONE_PRIMARY: assert property ($onehot(role_sel_o))
    else $error("not exactly one primary device");

  AST_SLAVE_INHIBIT: assert property (
    block_slave_writes_i |=> !slave_wr_inhibit_n_o)
    else $error("subordinate write inhibit not applied");

  AST_REQ_WRITES_ZERO: assert property (
    (cyc.req && cyc.ready && st_q == HC_ACQ_WR) |-> (cyc.we && !cyc.wdata[0]))
    else $error("token request did not write zero");

  AST_REL_WRITES_ONE: assert property (
    (cyc.req && cyc.ready && st_q == HC_REL) |-> (cyc.we && cyc.wdata[0]))
    else $error("token release did not write one");

  AST_GRANT_AFTER_ZERO: assert property (
    (rsp_valid_o && rsp_granted_o) |-> ($past(st_q) == HC_ACQ_RD && !$past(cyc.rdata[0])))
    else $error("ownership claimed without reading zero");

  AST_INIT_ALL_TOKENS: assert property (
    (st_q == HC_INIT && cyc.done && idx_q != 3'h7) |=> (st_q == HC_INIT))
    else $error("init finished before all tokens written");
endmodule : dpbs_host_ctrl

// ---- rtl/dpbs_pkg.sv ----
package dpbs_pkg;
  // ----------------------------------------------------------------
  // pin widths and token space
  // ----------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int TOKEN_CNT = 8;
  localparam int TOK_IDX_W = 3;
  localparam int NUM_DEV = 2;
  localparam int CNT_W = 4;

  // ----------------------------------------------------------------
  // timing: figures in ns, counts derived from the 4 ns clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int T_SETUP_NS = 25;
  localparam int T_ACCESS_NS = 25;
  localparam int T_WPULSE_NS = 20;
  localparam int T_HOLD_NS = 4;
  localparam int T_GAP_NS = 8;
  // least times: round up
  localparam int SETUP_CYC = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACCESS_CYC = (T_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WPULSE_CYC = (T_WPULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_CYC = (T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int GAP_CYC = (T_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // reset values and fixed roles
  // ----------------------------------------------------------------
  localparam logic [NUM_DEV-1:0] ROLE_SEL_RST = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [DATA_W-1:0] TOK_FREE = 8'h01;
  localparam logic [DATA_W-1:0] TOK_REQ = 8'h00;
  localparam int TOK_BIT = 0;

  // ----------------------------------------------------------------
  // commands
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_MEM_RD = 3'h0,
    CMD_MEM_WR = 3'h1,
    CMD_TOK_ACQ = 3'h2,
    CMD_TOK_REL = 3'h3,
    CMD_TOK_INIT = 3'h4
  } dpbs_cmd_t;
endpackage : dpbs_pkg

// ---- rtl/dpbs_cyc_if.sv ----
`timescale 1ns/1ps
interface dpbs_cyc_if;
  logic req;
  logic ready;
  logic we;
  logic tok;
  logic [dpbs_pkg::ADDR_W-1:0] addr;
  logic [dpbs_pkg::DATA_W-1:0] wdata;
  logic done;
  logic blocked;
  logic [dpbs_pkg::DATA_W-1:0] rdata;

  modport ctl (output req, we, tok, addr, wdata, input ready, done, blocked, rdata);
  modport eng (input req, we, tok, addr, wdata, output ready, done, blocked, rdata);
endinterface : dpbs_cyc_if

// ---- rtl/dpbs_pin_cycle.sv ----
`timescale 1ns/1ps
module dpbs_pin_cycle (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // request side
  dpbs_cyc_if.eng cyc,
  // device port pins
  output logic ce_n_o,
  output logic token_space_select_n_o,
  output logic oe_n_o,
  output logic rw_n_o,
  output logic [dpbs_pkg::ADDR_W-1:0] addr_o,
  output logic [dpbs_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic [dpbs_pkg::DATA_W-1:0] data_i,
  input wire logic [dpbs_pkg::NUM_DEV-1:0] busy_n_i
);
  typedef enum logic [4:0] {
    PC_IDLE = 5'h01,
    PC_SETUP = 5'h02,
    PC_STROBE = 5'h04,
    PC_HOLD = 5'h08,
    PC_GAP = 5'h10
  } dpbs_pc_st_t;

  dpbs_pc_st_t st_q;
  logic [dpbs_pkg::CNT_W-1:0] cnt_q;
  logic we_q;
  logic tok_q;
  logic busy_all;

  // stacked devices each pull their own flag low; any low means contention
  assign busy_all = &busy_n_i;

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q <= PC_IDLE;
      cnt_q <= '0;
      we_q <= 1'b0;
      tok_q <= 1'b0;
      ce_n_o <= 1'b1;
      token_space_select_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      rw_n_o <= 1'b1;
      addr_o <= dpbs_pkg::ADDR_RST;
      data_o <= dpbs_pkg::DATA_RST;
      data_oe_o <= 1'b0;
      cyc.done <= 1'b0;
      cyc.blocked <= 1'b0;
      cyc.rdata <= dpbs_pkg::DATA_RST;
    end else begin
      cyc.done <= 1'b0;
      unique case (st_q)
        PC_IDLE: begin
          if (cyc.req) begin
            we_q <= cyc.we;
            tok_q <= cyc.tok;
            ce_n_o <= cyc.tok;
            token_space_select_n_o <= ~cyc.tok;
            oe_n_o <= cyc.we;
            addr_o <= cyc.addr;
            data_o <= cyc.wdata;
            data_oe_o <= cyc.we;
            cyc.blocked <= 1'b0;
            // hold address and select long enough for the busy verdict
            cnt_q <= dpbs_pkg::CNT_W'(dpbs_pkg::SETUP_CYC - 1);
            st_q <= PC_SETUP;
          end
        end
        PC_SETUP: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else if (!we_q) begin
            // setup already covers the access time, data is valid here
            cyc.rdata <= data_i;
            ce_n_o <= 1'b1;
            token_space_select_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            cnt_q <= dpbs_pkg::CNT_W'(dpbs_pkg::GAP_CYC - 1);
            st_q <= PC_GAP;
          end else if (!tok_q && !busy_all) begin
            // losing side: do not strobe, report so the caller may retry
            cyc.blocked <= 1'b1;
            ce_n_o <= 1'b1;
            data_oe_o <= 1'b0;
            cnt_q <= dpbs_pkg::CNT_W'(dpbs_pkg::GAP_CYC - 1);
            st_q <= PC_GAP;
          end else begin
            rw_n_o <= 1'b0;
            cnt_q <= dpbs_pkg::CNT_W'(dpbs_pkg::WPULSE_CYC - 1);
            st_q <= PC_STROBE;
          end
        end
        PC_STROBE: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            rw_n_o <= 1'b1;
            cnt_q <= dpbs_pkg::CNT_W'(dpbs_pkg::HOLD_CYC - 1);
            st_q <= PC_HOLD;
          end
        end
        PC_HOLD: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            ce_n_o <= 1'b1;
            token_space_select_n_o <= 1'b1;
            data_oe_o <= 1'b0;
            cnt_q <= dpbs_pkg::CNT_W'(dpbs_pkg::GAP_CYC - 1);
            st_q <= PC_GAP;
          end
        end
        PC_GAP: begin
          // selects stay high so the next token read recaptures the flag
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            cyc.done <= 1'b1;
            st_q <= PC_IDLE;
          end
        end
        default: begin
          st_q <= PC_IDLE;
        end
      endcase
    end
  end

  assign cyc.ready = (st_q == PC_IDLE);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_select_start;
    $fell(ce_n_o && token_space_select_n_o);
  endsequence

  sequence s_quiet_setup;
    rw_n_o [*7];
  endsequence

  AST_SETUP_BEFORE_STROBE: assert property (s_select_start |-> s_quiet_setup)
    else $error("write strobe started before address setup elapsed");

  AST_NO_WRITE_WHILE_BUSY: assert property (
    ($fell(rw_n_o) && !ce_n_o) |-> $past(busy_all))
    else $error("memory write strobed while contention reported");

  AST_GAP_BETWEEN_READS: assert property (
    $rose(ce_n_o && token_space_select_n_o) |-> (ce_n_o && token_space_select_n_o) [*2])
    else $error("selects not held inactive between cycles");

  AST_IDLE_STANDBY: assert property ((st_q == PC_IDLE) |-> (ce_n_o && token_space_select_n_o))
    else $error("port not in standby while idle");
endmodule : dpbs_pin_cycle

// ---- verif/dpbs_dev_model.sv ----
`timescale 1ns/1ps
module dpbs_dev_model #(
  parameter realtime T_SETUP = 20.0
) (
  // host port pins
  input wire logic ce_n_i,
  input wire logic token_space_select_n_i,
  input wire logic oe_n_i,
  input wire logic rw_n_i,
  input wire logic [dpbs_pkg::ADDR_W-1:0] addr_i,
  input wire logic [dpbs_pkg::DATA_W-1:0] dq_i,
  output logic [dpbs_pkg::DATA_W-1:0] dq_o,
  output logic [dpbs_pkg::NUM_DEV-1:0] busy_n_o,
  input wire logic [dpbs_pkg::NUM_DEV-1:0] role_sel_i,
  // far port, driven by the bench
  input wire logic far_ce_n_i,
  input wire logic [dpbs_pkg::ADDR_W-1:0] far_addr_i,
  input wire logic far_tok_wr_i,
  input wire logic [dpbs_pkg::TOK_IDX_W-1:0] far_idx_i,
  input wire logic far_val_i,
  // observation
  output logic [dpbs_pkg::TOKEN_CNT-1:0] far_flag_o,
  output logic [dpbs_pkg::TOKEN_CNT-1:0] free_o,
  output int viol_o
);
  // owner code: 0 free, 1 host side, 2 far side
  logic [1:0] own [dpbs_pkg::TOKEN_CNT];
  logic req_h [dpbs_pkg::TOKEN_CNT];
  logic req_f [dpbs_pkg::TOKEN_CNT];
  logic [7:0] mem [0:32767];
  logic [7:0] last;
  logic tok_latch;
  logic match;
  realtime t_sel;

  // latches power up holding a stale host-side claim, so skipping init shows
  initial begin
    for (int i = 0; i < dpbs_pkg::TOKEN_CNT; i++) begin
      own[i] = 2'h1;
      req_h[i] = 1'b0;
      req_f[i] = 1'b1;
    end
    for (int i = 0; i < 32768; i++) mem[i] = 8'h00;
    last = 8'h00;
    tok_latch = 1'b1;
    viol_o = 0;
    t_sel = 0;
  end

  task automatic tok_write(input logic [1:0] side, input int i, input logic v);
    if (side == 2'h1) req_h[i] = v; else req_f[i] = v;
    if (!v && own[i] == 2'h0) own[i] = side;
    if (v && own[i] == side) begin
      own[i] = ((side == 2'h1) ? req_f[i] : req_h[i]) ? 2'h0 : 2'h3 - side;
    end
  endtask : tok_write

  always @* begin
    for (int i = 0; i < dpbs_pkg::TOKEN_CNT; i++) begin
      far_flag_o[i] = (own[i] != 2'h2);
      free_o[i] = (own[i] == 2'h0);
    end
  end

  // the bench always settles the far side first, so the host port loses
  assign match = !ce_n_i && !far_ce_n_i && (addr_i == far_addr_i);
  assign busy_n_o[0] = role_sel_i[0] ? !match : 1'b1;
  assign busy_n_o[1] = 1'b1;

  always @(posedge rw_n_i) begin
    if (!token_space_select_n_i && ce_n_i) begin
      tok_write(2'h1, int'(addr_i[2:0]), dq_i[0]);
    end else if (!ce_n_i && token_space_select_n_i && busy_n_o[0]) begin
      mem[addr_i] = dq_i;
    end
  end

  always @(posedge far_tok_wr_i) tok_write(2'h2, int'(far_idx_i), far_val_i);

  always @(negedge (ce_n_i & token_space_select_n_i) or addr_i) t_sel = $realtime;

  always @(negedge rw_n_i) begin
    if ($realtime - t_sel < T_SETUP) viol_o++;
  end

  always @(negedge (token_space_select_n_i | oe_n_i)) begin
    tok_latch = (own[addr_i[2:0]] != 2'h1);
  end

  // a released bus shows the inverse of its last value, never a held copy
  always @(ce_n_i or oe_n_i or rw_n_i or token_space_select_n_i or addr_i or tok_latch) begin
    if (!token_space_select_n_i && !oe_n_i && ce_n_i) begin
      dq_o = {8{tok_latch}};
      last = dq_o;
    end else if (!ce_n_i && !oe_n_i && rw_n_i) begin
      dq_o = mem[addr_i];
      last = dq_o;
    end else begin
      dq_o = ~last;
    end
  end
endmodule : dpbs_dev_model

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic clk_i, srst_i, cmd_valid_i, block_slave_writes_i;
  dpbs_pkg::dpbs_cmd_t cmd_i;
  logic [dpbs_pkg::ADDR_W-1:0] cmd_addr_i, addr_o, far_addr;
  logic [dpbs_pkg::DATA_W-1:0] cmd_wdata_i, rsp_data_o, data_o, dev_dq, dq;
  logic cmd_ready_o, rsp_valid_o, rsp_granted_o, rsp_blocked_o, slave_wr_inhibit_n_o;
  logic ce_n_o, token_space_select_n_o, oe_n_o, rw_n_o, data_oe_o;
  logic [dpbs_pkg::NUM_DEV-1:0] role_sel_o, busy_n;
  logic far_ce_n, far_tok_wr, far_val;
  logic [dpbs_pkg::TOK_IDX_W-1:0] far_idx;
  logic [dpbs_pkg::TOKEN_CNT-1:0] far_flag, free_mask;
  int viol;
  int mismatches;
  int cmp_count;

  assign dq = data_oe_o ? data_o : dev_dq;

  dpbs_host_ctrl i_dut (
    .clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_granted_o(rsp_granted_o), .rsp_blocked_o(rsp_blocked_o),
    .rsp_data_o(rsp_data_o), .block_slave_writes_i(block_slave_writes_i),
    .slave_wr_inhibit_n_o(slave_wr_inhibit_n_o), .role_sel_o(role_sel_o), .ce_n_o(ce_n_o),
    .token_space_select_n_o(token_space_select_n_o), .oe_n_o(oe_n_o), .rw_n_o(rw_n_o),
    .addr_o(addr_o), .data_o(data_o), .data_oe_o(data_oe_o), .data_i(dq), .busy_n_i(busy_n)
  );

  dpbs_dev_model i_dev (
    .ce_n_i(ce_n_o), .token_space_select_n_i(token_space_select_n_o), .oe_n_i(oe_n_o),
    .rw_n_i(rw_n_o), .addr_i(addr_o), .dq_i(dq), .dq_o(dev_dq), .busy_n_o(busy_n),
    .role_sel_i(role_sel_o), .far_ce_n_i(far_ce_n), .far_addr_i(far_addr),
    .far_tok_wr_i(far_tok_wr), .far_idx_i(far_idx), .far_val_i(far_val),
    .far_flag_o(far_flag), .free_o(free_mask), .viol_o(viol)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic end_sim;
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  // bounded wait on a design flag; a hang ends the run
  task automatic wait_high(ref logic sig, input int lim);
    int n;
    n = 0;
    while (sig !== 1'b1) begin
      tick(1);
      n++;
      if (n > lim) begin
        check(32'h0, 32'h1);
        end_sim();
      end
    end
  endtask : wait_high

  task automatic run_cmd(input dpbs_pkg::dpbs_cmd_t c, input logic [14:0] a, input logic [7:0] d);
    wait_high(cmd_ready_o, 50);
    cmd_i = c;
    cmd_addr_i = a;
    cmd_wdata_i = d;
    cmd_valid_i = 1'b1;
    tick(1);
    cmd_valid_i = 1'b0;
    wait_high(rsp_valid_o, 400);
  endtask : run_cmd

  task automatic far_tok(input logic [2:0] i, input logic v);
    far_idx = i;
    far_val = v;
    far_tok_wr = 1'b1;
    tick(1);
    far_tok_wr = 1'b0;
  endtask : far_tok

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    tick(10);
    check({ce_n_o, token_space_select_n_o, oe_n_o, rw_n_o, data_oe_o}, 32'h1E);
    check(role_sel_o, 32'h1);
    check({slave_wr_inhibit_n_o, cmd_ready_o}, 32'h2);
    srst_i = 1'b0;
    check(cmd_ready_o, 32'h0);
    tick(1);
    check(cmd_ready_o, 32'h1);
    tick(1);
    check(cmd_ready_o, 32'h1);
  endtask : t_reset

  task automatic t_init;
    check(free_mask, 32'h00);
    run_cmd(dpbs_pkg::CMD_TOK_INIT, 15'h0000, 8'h00);
    check(free_mask, 32'hFF);
  endtask : t_init

  task automatic t_mem_busy;
    run_cmd(dpbs_pkg::CMD_MEM_WR, 15'h7FFF, 8'hA5);
    run_cmd(dpbs_pkg::CMD_MEM_RD, 15'h7FFF, 8'h00);
    check(rsp_data_o, 32'hA5);
    run_cmd(dpbs_pkg::CMD_MEM_WR, 15'h0123, 8'h11);
    check(rsp_blocked_o, 32'h0);
    far_addr = 15'h0123;
    far_ce_n = 1'b0;
    run_cmd(dpbs_pkg::CMD_MEM_WR, 15'h0123, 8'h5A);
    check(rsp_blocked_o, 32'h1);
    far_ce_n = 1'b1;
    run_cmd(dpbs_pkg::CMD_MEM_RD, 15'h0123, 8'h00);
    check(rsp_data_o, 32'h11);
    run_cmd(dpbs_pkg::CMD_MEM_WR, 15'h0123, 8'h5A);
    check(rsp_blocked_o, 32'h0);
    run_cmd(dpbs_pkg::CMD_MEM_RD, 15'h0123, 8'h00);
    check(rsp_data_o, 32'h5A);
  endtask : t_mem_busy

  task automatic t_token_pass;
    run_cmd(dpbs_pkg::CMD_TOK_ACQ, 15'h7FFB, 8'h00);
    check({rsp_granted_o, rsp_data_o}, 32'h100);
    check(far_flag[3], 32'h1);
    far_tok(3'h3, 1'b0);
    check(far_flag[3], 32'h1);
    run_cmd(dpbs_pkg::CMD_TOK_REL, 15'h0003, 8'h00);
    check(far_flag[3], 32'h0);
    run_cmd(dpbs_pkg::CMD_TOK_ACQ, 15'h0003, 8'h00);
    check({rsp_granted_o, rsp_data_o}, 32'h0FF);
    far_tok(3'h3, 1'b1);
    check({far_flag[3], free_mask[3]}, 32'h2);
    run_cmd(dpbs_pkg::CMD_TOK_ACQ, 15'h0003, 8'h00);
    check(rsp_granted_o, 32'h1);
    run_cmd(dpbs_pkg::CMD_TOK_REL, 15'h0003, 8'h00);
    check(free_mask[3], 32'h1);
    far_tok(3'h5, 1'b0);
    run_cmd(dpbs_pkg::CMD_TOK_ACQ, 15'h0005, 8'h00);
    check(rsp_granted_o, 32'h0);
    far_tok(3'h5, 1'b1);
    run_cmd(dpbs_pkg::CMD_TOK_REL, 15'h0005, 8'h00);
    check(free_mask[5], 32'h1);
  endtask : t_token_pass

  task automatic t_token_all;
    for (int i = 0; i < dpbs_pkg::TOKEN_CNT; i++) begin
      run_cmd(dpbs_pkg::CMD_TOK_ACQ, {12'hA5C, i[2:0]}, 8'h00);
      check(rsp_granted_o, 32'h1);
      check(free_mask[i], 32'h0);
      run_cmd(dpbs_pkg::CMD_TOK_REL, {12'h3C5, i[2:0]}, 8'h00);
    end
    check(free_mask, 32'hFF);
  endtask : t_token_all

  task automatic t_inhibit;
    block_slave_writes_i = 1'b1;
    tick(2);
    check(slave_wr_inhibit_n_o, 32'h0);
    block_slave_writes_i = 1'b0;
    tick(2);
    check(slave_wr_inhibit_n_o, 32'h1);
  endtask : t_inhibit

  initial begin
    mismatches = 0;
    cmp_count = 0;
    srst_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_i = dpbs_pkg::CMD_MEM_RD;
    cmd_addr_i = 15'h0000;
    cmd_wdata_i = 8'h00;
    block_slave_writes_i = 1'b0;
    far_ce_n = 1'b1;
    far_addr = 15'h0000;
    far_tok_wr = 1'b0;
    far_idx = 3'h0;
    far_val = 1'b1;
    t_reset();
    t_init();
    t_mem_busy();
    t_token_pass();
    t_token_all();
    t_inhibit();
    check(viol, 32'h0);
    end_sim();
  end
endmodule : tb
